/* common/lcc_defines.vh */
/*
 * Constants for the look-aside cache cycle-response block.
 * Assumes a 200 MHz sys_clk_in and a processor-style bus sampled through synchronisers.
 */
// Overview of operation
// - Cache only main-memory cycles flagged by controller
// - Controller starts memory cycle in parallel
// - Cacheable miss: RAM outputs off, miss low
// - Read miss allocates block, writes returned data
// - Write miss leaves directory untouched
// - Read hit: miss high, RAM data, own ready
// - Writeable write hit writes cache RAM
// - Noncacheable read: miss, no RAM, directory unchanged
// - Main-memory writes classified cacheable
// - No allocation during hold acknowledge
// - Hold-ack write hit clears one line valid
// - Replace least recently hit way
// - Registers decoded from I/O strobes
// - Drive low and high bus byte enables
// - Master input low admits DMA register access
// - Code read hit aborts controller read
// - Data writes keep miss low always
// - Hold ack: ignore status, watch write strobe
// - Write-protected hit leaves RAM unchanged
// - Block of four or eight lines, per-line valid
`ifndef LCC_DEFINES_VH
`define LCC_DEFINES_VH
// Cycle type codes {mem_io, data_code, write_read}.
`define LCC_CYC_IACK 3'h0
`define LCC_CYC_HALT_IO 3'h1
`define LCC_CYC_IO_RD 3'h2
`define LCC_CYC_IO_WR 3'h3
`define LCC_CYC_CODE_RD 3'h4
`define LCC_CYC_HALT 3'h5
`define LCC_CYC_DATA_RD 3'h6
`define LCC_CYC_DATA_WR 3'h7
// Directory shape.
`define LCC_INDEX_BITS 10
`define LCC_LINE_BITS_16K 2
`define LCC_LINE_BITS_32K 3
// Cycles the cache read-hit data is held before ready.
`define LCC_HIT_WAIT 2'h2
`endif

/* design/lcc_cycle_response.v */
/*
 * Cycle-response logic of a two-way look-aside, read-allocate, write-through cache.
 * Assumes all bus inputs are asynchronous to sys_clk_in and are synchronised here; the
 * system controller finishes miss and write cycles with its own ready.
 */
`include "lcc_defines.vh"

module lcc_cycle_response #(
    parameter ADDR_BITS = 23,   // Word address bits A23..A1.
    parameter BIG_CACHE = 1     // 1 = 32KB (eight lines per block), 0 = 16KB (four lines).
) (
    input wire sys_clk_in,                 // System clock.
    input wire rst_in,                     // Power-on reset, asynchronous, active high.
    input wire cpu_reset_in,               // Processor reset: restarts the cycle tracker only.
    input wire [ADDR_BITS-1:0] addr_in,    // Processor word address.
    input wire addr_strobe_n_in,           // Start of a processor bus cycle, active low.
    input wire mem_io_in,                  // 1 = memory, 0 = I/O.
    input wire data_code_in,               // 1 = data, 0 = code.
    input wire write_read_in,              // 1 = write, 0 = read.
    input wire byte_low_en_n_in,           // Processor low byte enable, active low.
    input wire byte_high_en_n_in,          // Processor high byte enable, active low.
    input wire ready_n_in,                 // Processor ready, active low.
    input wire hold_ack_in,                // Another master owns the bus.
    input wire memory_write_strobe_n_in,   // Memory write strobe, active low.
    input wire io_read_strobe_n_in,        // I/O read strobe, active low.
    input wire io_write_strobe_n_in,       // I/O write strobe, active low.
    input wire master_n_in,                // Master-mode register access allowed, active low.
    input wire reg_select_in,              // Address decode of this block's I/O ports.
    input wire main_memory_in,             // Address belongs to controller main memory.
    input wire noncache_cycle_n_in,        // Non-cacheable cycle, active low.
    input wire write_protect_cycle_n_in,   // Write-protected cycle, active low.
    input wire cache_enable_in,            // Cache enabled by configuration.
    output reg miss_n_out,                 // Miss to system controller, active low.
    output reg ready_n_out,                // Own ready for read hits, active low.
    output reg cache_oe_a_n_out,           // Cache RAM set A output enable, active low.
    output reg cache_oe_b_n_out,           // Cache RAM set B output enable, active low.
    output reg cache_we_a_n_out,           // Cache RAM set A write enable, active low.
    output reg cache_we_b_n_out,           // Cache RAM set B write enable, active low.
    output reg bus_low_byte_en_n_out,      // Low data byte used this cycle, active low.
    output reg bus_high_byte_en_n_out,     // High data byte used this cycle, active low.
    output reg reg_read_out,               // One-cycle pulse: configuration register read.
    output reg reg_write_out               // One-cycle pulse: configuration register write.
);
    // ****************************************************************
    // Local shape
    // ****************************************************************
    localparam LB = BIG_CACHE ? `LCC_LINE_BITS_32K : `LCC_LINE_BITS_16K;
    localparam NL = 1 << LB;                  // Lines per block.
    localparam IB = `LCC_INDEX_BITS;
    localparam TB = ADDR_BITS - IB - LB;      // Tag width.
    localparam ENT = 1 << IB;
    localparam NS = 16;                       // Number of synchronised bits.
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_HIT = 3'h1;
    localparam [2:0] ST_WAIT = 3'h2;

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    wire [NS-1:0] raw_in = {cpu_reset_in, addr_strobe_n_in, mem_io_in, data_code_in,
        write_read_in, byte_low_en_n_in, byte_high_en_n_in, ready_n_in, hold_ack_in,
        memory_write_strobe_n_in, io_read_strobe_n_in, io_write_strobe_n_in, master_n_in,
        main_memory_in, noncache_cycle_n_in, write_protect_cycle_n_in};
    reg [NS-1:0] sync1_q;                     // First stage, read only by the second.
    reg [NS-1:0] sync2_q;                     // Second stage, safe to use.
    reg [ADDR_BITS-1:0] addr1_q;              // Address first stage.
    reg [ADDR_BITS-1:0] addr2_q;              // Address second stage.
    reg [1:0] en1_q;                          // Other level inputs, first stage.
    reg [1:0] en2_q;                          // Other level inputs, second stage.
    reg ads_prev_q;                           // Previous synchronised address strobe.
    reg mw_prev_q;                            // Previous synchronised memory write strobe.
    reg ird_prev_q;                           // Previous I/O read strobe.
    reg iwr_prev_q;                           // Previous I/O write strobe.

    // Bundled two-flop synchroniser for every asynchronous pin.
    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sync1_q <= 16'hffff;
            sync2_q <= 16'hffff;
            addr1_q <= {ADDR_BITS{1'b0}};
            addr2_q <= {ADDR_BITS{1'b0}};
            en1_q <= 2'h0;
            en2_q <= 2'h0;
        end else begin
            sync1_q <= raw_in;
            sync2_q <= sync1_q;
            addr1_q <= addr_in;
            addr2_q <= addr1_q;
            en1_q <= {cache_enable_in, reg_select_in};
            en2_q <= en1_q;
        end
    end

    wire s_cpurst = sync2_q[15];
    wire s_ads_n = sync2_q[14];
    wire [2:0] s_cyc = sync2_q[13:11];
    wire s_ble_n = sync2_q[10];
    wire s_bhe_n = sync2_q[9];
    wire s_rdy_n = sync2_q[8];
    wire s_hold = sync2_q[7];
    wire s_mwr_n = sync2_q[6];
    wire s_ird_n = sync2_q[5];
    wire s_iwr_n = sync2_q[4];
    wire s_master_n = sync2_q[3];
    wire s_mainmem = sync2_q[2];
    wire s_nc_n = sync2_q[1];
    wire s_wp_n = sync2_q[0];
    wire s_cen = en2_q[1];
    wire s_regsel = en2_q[0];

    // Cycle start on the falling edge of the address strobe, pipelined or not.
    wire cyc_start = ads_prev_q & ~s_ads_n & ~s_hold;
    // A hold-acknowledge write starts when the memory write strobe falls.
    wire dma_wr = mw_prev_q & ~s_mwr_n & s_hold;

    // ****************************************************************
    // Directory: tags, per-line valid bits, LRU bit
    // ****************************************************************
    reg [TB-1:0] tag_a_q [0:ENT-1];
    reg [TB-1:0] tag_b_q [0:ENT-1];
    reg [NL-1:0] val_a_q [0:ENT-1];           // One valid bit per line.
    reg [NL-1:0] val_b_q [0:ENT-1];
    reg [ENT-1:0] lru_q;                      // 1 = way A least recently hit.

    wire [LB-1:0] line = addr2_q[LB-1:0];
    wire [IB-1:0] idx = addr2_q[LB+IB-1:LB];
    wire [TB-1:0] tag = addr2_q[ADDR_BITS-1:LB+IB];
    wire hit_a = (tag_a_q[idx] == tag) & val_a_q[idx][line];
    wire hit_b = (tag_b_q[idx] == tag) & val_b_q[idx][line];
    wire hit = s_cen & (hit_a | hit_b);
    // Cycle classification.
    wire is_write = s_cyc == `LCC_CYC_DATA_WR;
    wire is_read = (s_cyc == `LCC_CYC_CODE_RD) | (s_cyc == `LCC_CYC_DATA_RD);
    // Writes are cacheable regardless of the non-cache input.
    wire cacheable = s_cen & s_mainmem & (is_write | s_nc_n);
    wire writeable = s_wp_n;

    // ****************************************************************
    // Cycle state
    // ****************************************************************
    reg [2:0] state_q;
    reg way_q;                                // Way used by current cycle (1 = B).
    reg alloc_q;                              // Current cycle is a read-miss fill.
    reg [IB-1:0] idx_q;
    reg [LB-1:0] line_q;
    reg [1:0] cnt_q;                          // Hit data hold counter.
    wire victim_b = (tag_b_q[idx] == tag) | (~(tag_a_q[idx] == tag) & ~lru_q[idx]);
    integer i;

    // Main response process: miss, ready, RAM strobes and directory update.
    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= ST_IDLE;
            way_q <= 1'b0;
            alloc_q <= 1'b0;
            idx_q <= {IB{1'b0}};
            line_q <= {LB{1'b0}};
            cnt_q <= 2'h0;
            lru_q <= {ENT{1'b0}};
            for (i = 0; i < ENT; i = i + 1) begin
                val_a_q[i] <= {NL{1'b0}};
                val_b_q[i] <= {NL{1'b0}};
                tag_a_q[i] <= {TB{1'b0}};
                tag_b_q[i] <= {TB{1'b0}};
            end
            miss_n_out <= 1'b1;
            ready_n_out <= 1'b1;
            cache_oe_a_n_out <= 1'b1;
            cache_oe_b_n_out <= 1'b1;
            cache_we_a_n_out <= 1'b1;
            cache_we_b_n_out <= 1'b1;
            bus_low_byte_en_n_out <= 1'b1;
            bus_high_byte_en_n_out <= 1'b1;
        end else if (s_cpurst) begin
            // Processor reset only resynchronises the cycle tracker; directory survives.
            state_q <= ST_IDLE;
            alloc_q <= 1'b0;
            miss_n_out <= 1'b1;
            ready_n_out <= 1'b1;
            cache_oe_a_n_out <= 1'b1;
            cache_oe_b_n_out <= 1'b1;
            cache_we_a_n_out <= 1'b1;
            cache_we_b_n_out <= 1'b1;
        end else begin
            // Hold-acknowledge write hit invalidates only the addressed line.
            if (dma_wr & hit) begin
                if (hit_a)
                    val_a_q[idx] <= val_a_q[idx] & ~({{(NL-1){1'b0}}, 1'b1} << line);
                else
                    val_b_q[idx] <= val_b_q[idx] & ~({{(NL-1){1'b0}}, 1'b1} << line);
            end
            case (state_q)
                ST_IDLE: begin
                    cache_we_a_n_out <= 1'b1;
                    cache_we_b_n_out <= 1'b1;
                    ready_n_out <= 1'b1;
                    if (cyc_start) begin
                        // Byte enables follow the processor's byte use.
                        bus_low_byte_en_n_out <= s_ble_n;
                        bus_high_byte_en_n_out <= s_bhe_n;
                        idx_q <= idx;
                        line_q <= line;
                        way_q <= hit_b;
                        state_q <= ST_WAIT;
                        miss_n_out <= 1'b0;
                        if (is_read & cacheable & hit) begin
                            // Read hit: drive cache data, own ready, abort controller.
                            miss_n_out <= 1'b1;
                            cache_oe_a_n_out <= ~hit_a;
                            cache_oe_b_n_out <= ~hit_b;
                            lru_q[idx] <= hit_b;
                            cnt_q <= `LCC_HIT_WAIT;
                            state_q <= ST_HIT;
                        end else if (is_read & cacheable) begin
                            // Read miss: allocate the way already holding the tag, else the least recently hit way.
                            alloc_q <= 1'b1;
                            way_q <= victim_b;
                            lru_q[idx] <= victim_b;
                            if (victim_b) begin
                                tag_b_q[idx] <= tag;
                                if (tag_b_q[idx] != tag)
                                    val_b_q[idx] <= {NL{1'b0}};
                            end else begin
                                tag_a_q[idx] <= tag;
                                if (tag_a_q[idx] != tag)
                                    val_a_q[idx] <= {NL{1'b0}};
                            end
                        end else if (is_write & cacheable & hit) begin
                            // Write-through hit; protected regions leave RAM alone.
                            lru_q[idx] <= hit_b;
                            cache_we_a_n_out <= ~(hit_a & writeable);
                            cache_we_b_n_out <= ~(hit_b & writeable);
                        end
                        // Write miss and non-cacheable reads touch nothing.
                    end
                end
                ST_HIT: begin
                    if (cnt_q == 2'h1)
                        ready_n_out <= 1'b0;
                    if (cnt_q == 2'h0) begin
                        ready_n_out <= 1'b1;
                        cache_oe_a_n_out <= 1'b1;
                        cache_oe_b_n_out <= 1'b1;
                        miss_n_out <= 1'b1;
                        state_q <= ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 2'h1;
                    end
                end
                ST_WAIT: begin
                    // The controller ends miss and write cycles with its ready.
                    cache_we_a_n_out <= 1'b1;
                    cache_we_b_n_out <= 1'b1;
                    if (~s_rdy_n) begin
                        if (alloc_q) begin
                            // Capture returned data and mark the line valid.
                            cache_we_a_n_out <= way_q;
                            cache_we_b_n_out <= ~way_q;
                            if (way_q)
                                val_b_q[idx_q] <= val_b_q[idx_q] |
                                    ({{(NL-1){1'b0}}, 1'b1} << line_q);
                            else
                                val_a_q[idx_q] <= val_a_q[idx_q] |
                                    ({{(NL-1){1'b0}}, 1'b1} << line_q);
                        end
                        alloc_q <= 1'b0;
                        miss_n_out <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // Register strobe decode and edge history
    // ****************************************************************
    // Register access is decoded from I/O strobes; DMA masters need the master input low.
    wire reg_ok = s_regsel & (~s_hold | ~s_master_n);

    // Edge detectors and register access pulses.
    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ads_prev_q <= 1'b1;
            mw_prev_q <= 1'b1;
            ird_prev_q <= 1'b1;
            iwr_prev_q <= 1'b1;
            reg_read_out <= 1'b0;
            reg_write_out <= 1'b0;
        end else begin
            ads_prev_q <= s_ads_n;
            mw_prev_q <= s_mwr_n;
            ird_prev_q <= s_ird_n;
            iwr_prev_q <= s_iwr_n;
            reg_read_out <= reg_ok & ird_prev_q & ~s_ird_n;
            reg_write_out <= reg_ok & iwr_prev_q & ~s_iwr_n;
        end
    end
endmodule // lcc_cycle_response

/* bench/lcc_cycle_monitor.sv */
/* Concurrent checks on the cache cycle-response block.
   Assumes it is bound to the block and sees only the block's ports. */
module lcc_cycle_monitor (
    input wire sys_clk_in,
    input wire rst_in,
    input wire io_read_strobe_n_in,
    input wire miss_n_out,
    input wire ready_n_out,
    input wire cache_oe_a_n_out,
    input wire cache_oe_b_n_out,
    input wire cache_we_a_n_out,
    input wire cache_we_b_n_out,
    input wire reg_read_out,
    input wire reg_write_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // Cycles since the read strobe was last seen low; saturates so it never wraps.
    logic [3:0] since_q;
    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            since_q <= 4'hf;
        end else if (!io_read_strobe_n_in) begin
            since_q <= 4'h0;
        end else if (since_q != 4'hf) begin
            since_q <= since_q + 4'h1;
        end
    end
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    // ****************************************
    // Checks
    // ****************************************
    a_hit_not_miss: assert property (!ready_n_out |-> miss_n_out)
        else $error("own ready while miss is low");
    a_ready_pulse: assert property (!ready_n_out |=> ready_n_out)
        else $error("own ready longer than one cycle");
    a_hit_has_oe: assert property (!ready_n_out |-> !(cache_oe_a_n_out && cache_oe_b_n_out))
        else $error("own ready without cache output");
    a_miss_no_oe: assert property (!miss_n_out |-> cache_oe_a_n_out && cache_oe_b_n_out)
        else $error("cache output enabled during miss");
    a_oe_one_way: assert property (cache_oe_a_n_out || cache_oe_b_n_out)
        else $error("both ways drive data");
    a_we_one_way: assert property (cache_we_a_n_out || cache_we_b_n_out)
        else $error("both ways written");
    a_we_pulse: assert property ($fell(cache_we_a_n_out) |=> cache_we_a_n_out)
        else $error("write enable longer than one cycle");
    a_hit_no_we: assert property (!ready_n_out |-> cache_we_a_n_out && cache_we_b_n_out)
        else $error("cache written on read hit");
    a_reg_cause: assert property (reg_read_out |-> since_q <= 4'h6)
        else $error("register read without read strobe");
    a_reg_exclusive: assert property (!(reg_read_out && reg_write_out))
        else $error("register read and write together");
    c_read_hit: cover property (!ready_n_out);
    c_miss: cover property ($fell(miss_n_out));
    c_write_b: cover property (!cache_we_b_n_out);
    c_reg_write: cover property (reg_write_out);
endmodule // lcc_cycle_monitor

bind lcc_cycle_response lcc_cycle_monitor mon (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .io_read_strobe_n_in(io_read_strobe_n_in), .miss_n_out(miss_n_out),
    .ready_n_out(ready_n_out), .cache_oe_a_n_out(cache_oe_a_n_out),
    .cache_oe_b_n_out(cache_oe_b_n_out), .cache_we_a_n_out(cache_we_a_n_out),
    .cache_we_b_n_out(cache_we_b_n_out), .reg_read_out(reg_read_out),
    .reg_write_out(reg_write_out));

/* bench/lcc_sysctl_model.sv */
/* Behavioural system controller that finishes miss and write cycles.
   Assumes the bench changes inputs on the falling clock edge, as this model does. */
module lcc_sysctl_model (
    input wire clk_in,
    input wire rst_in,
    input wire miss_n_in,
    input wire cache_ready_n_in,
    input wire [3:0] wait_in,
    output wire cpu_ready_n_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic ctrl_ready_n_q; // Controller's own ready, active low.
    logic done_q; // Set once this cycle has been answered.
    logic [3:0] cnt_q; // Wait states spent in the current cycle.
    // The processor ready pin is the wired AND of both ready sources.
    assign cpu_ready_n_out = ctrl_ready_n_q & cache_ready_n_in;
    // A hit keeps miss high, so the memory cycle begun in parallel is dropped unanswered.
    always @(negedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_ready_n_q <= 1'b1;
            done_q <= 1'b0;
            cnt_q <= 4'h0;
        end else begin
            ctrl_ready_n_q <= 1'b1;
            if (miss_n_in) begin
                done_q <= 1'b0;
                cnt_q <= 4'h0;
            end else if (!done_q) begin
                cnt_q <= cnt_q + 4'h1;
                if (cnt_q == wait_in) begin
                    ctrl_ready_n_q <= 1'b0;
                    done_q <= 1'b1;
                end
            end
        end
    end
endmodule // lcc_sysctl_model

/* bench/lcc_cycle_response_tb.sv */
/* Self-checking bench for the cache cycle-response block.
   Assumes the controller model answers every cycle in which miss is low. */
`include "lcc_defines.vh"
module lcc_cycle_response_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [22:0] la = 23'h000100, lh = 23'h000200, lx = 23'h000400;
    localparam logic [22:0] tag1 = 23'h002000; // Next tag, same block index.
    logic sys_clk = 1'b0, rst = 1'b1, as_n = 1'b1, mio = 1'b1, dc = 1'b1, wr = 1'b0;
    logic ble_n = 1'b0, bhe_n = 1'b0, hold = 1'b0, mwr_n = 1'b1, ird_n = 1'b1;
    logic iwr_n = 1'b1, mst_n = 1'b1, rsel = 1'b0, mainm = 1'b1, nc_n = 1'b1, wp_n = 1'b1;
    logic [22:0] addr = 23'h0;
    logic [3:0] slow = 4'h2; // Controller wait states.
    wire rdy_in_n, miss_n, rdy_n, oea, oeb, wea, web, bbl, bbh, rrd, rwr;
    int err_total = 0, total_checks = 0, we_cnt, rdy_cnt;
    logic miss_seen, oe_seen;
    logic [1:0] be_seen;
    always #2.5 sys_clk = ~sys_clk;
    lcc_cycle_response #(.ADDR_BITS(23), .BIG_CACHE(1)) uut (.sys_clk_in(sys_clk),
        .rst_in(rst), .cpu_reset_in(1'b0), .addr_in(addr), .addr_strobe_n_in(as_n),
        .mem_io_in(mio), .data_code_in(dc), .write_read_in(wr), .byte_low_en_n_in(ble_n),
        .byte_high_en_n_in(bhe_n), .ready_n_in(rdy_in_n), .hold_ack_in(hold),
        .memory_write_strobe_n_in(mwr_n), .io_read_strobe_n_in(ird_n),
        .io_write_strobe_n_in(iwr_n), .master_n_in(mst_n), .reg_select_in(rsel),
        .main_memory_in(mainm), .noncache_cycle_n_in(nc_n), .write_protect_cycle_n_in(wp_n),
        .cache_enable_in(1'b1), .miss_n_out(miss_n), .ready_n_out(rdy_n),
        .cache_oe_a_n_out(oea), .cache_oe_b_n_out(oeb), .cache_we_a_n_out(wea),
        .cache_we_b_n_out(web), .bus_low_byte_en_n_out(bbl), .bus_high_byte_en_n_out(bbh),
        .reg_read_out(rrd), .reg_write_out(rwr));
    lcc_sysctl_model ctl (.clk_in(sys_clk), .rst_in(rst), .miss_n_in(miss_n),
        .cache_ready_n_in(rdy_n), .wait_in(slow), .cpu_ready_n_out(rdy_in_n));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // One processor cycle; the window is long enough for the slowest controller answer.
    task automatic cyc(input logic [22:0] a, input logic [2:0] st);
        @(negedge sys_clk);
        addr = a;
        {mio, dc, wr} = st;
        as_n = 1'b0;
        @(negedge sys_clk);
        as_n = 1'b1;
        {miss_seen, oe_seen, we_cnt, rdy_cnt} = '0;
        for (int i = 0; i < 24; i++) begin
            @(negedge sys_clk);
            miss_seen |= (miss_n === 1'b0);
            oe_seen |= (oea === 1'b0) || (oeb === 1'b0);
            we_cnt += (wea === 1'b0) + (web === 1'b0);
            rdy_cnt += (rdy_n === 1'b0);
            if (i == 6) be_seen = {bbh, bbl};
        end
    endtask
    task automatic exp(input string nm, input logic m, input logic o, input int w, input int r);
        check({nm, " miss"}, 32'(miss_seen), 32'(m));
        check({nm, " output enable"}, 32'(oe_seen), 32'(o));
        check({nm, " write pulses"}, we_cnt, w);
        check({nm, " own ready"}, rdy_cnt, r);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_read;
        cyc(la, `LCC_CYC_DATA_RD); exp("read miss", 1, 0, 1, 0);
        cyc(la, `LCC_CYC_DATA_RD); exp("read hit", 0, 1, 0, 1);
        cyc(la, `LCC_CYC_CODE_RD); exp("code hit", 0, 1, 0, 1);
        slow = 4'h9; // A slow controller still ends the miss itself.
        cyc(la + 23'h1, `LCC_CYC_CODE_RD); exp("slow miss", 1, 0, 1, 0);
        slow = 4'h2;
        mainm = 1'b0;
        cyc(la, `LCC_CYC_DATA_RD); exp("off memory", 1, 0, 0, 0);
        mainm = 1'b1;
        $display("test read done");
    endtask
    task automatic t_write;
        cyc(la, `LCC_CYC_DATA_WR); exp("write hit", 1, 0, 1, 0);
        wp_n = 1'b0;
        cyc(la, `LCC_CYC_DATA_WR); exp("protected hit", 1, 0, 0, 0);
        wp_n = 1'b1;
        nc_n = 1'b0; // Writes ignore the non-cache flag.
        cyc(la, `LCC_CYC_DATA_WR); exp("flagged write", 1, 0, 1, 0);
        cyc(la, `LCC_CYC_DATA_RD); exp("flagged read", 1, 0, 0, 0);
        nc_n = 1'b1;
        cyc(la, `LCC_CYC_DATA_RD); exp("kept line", 0, 1, 0, 1);
        cyc(la + tag1, `LCC_CYC_DATA_WR); exp("write miss", 1, 0, 0, 0);
        cyc(la + tag1, `LCC_CYC_DATA_RD); exp("not allocated", 1, 0, 1, 0);
        $display("test write done");
    endtask
    task automatic t_other;
        logic [2:0] codes [5];
        codes = '{`LCC_CYC_IACK, `LCC_CYC_HALT_IO, `LCC_CYC_IO_RD, `LCC_CYC_IO_WR, `LCC_CYC_HALT};
        foreach (codes[k]) begin
            cyc(la, codes[k]); exp("special cycle", 1, 0, 0, 0);
        end
        $display("test other cycles done");
    endtask
    task automatic t_hold;
        cyc(lh, `LCC_CYC_DATA_RD);
        cyc(lh + 23'h1, `LCC_CYC_DATA_RD); exp("fill", 1, 0, 1, 0);
        hold = 1'b1; // Another master owns the bus; processor status is ignored.
        cyc(lh + 23'h2, `LCC_CYC_DATA_RD); exp("hold status", 0, 0, 0, 0);
        addr = lh;
        mwr_n = 1'b0;
        repeat (4) @(negedge sys_clk);
        mwr_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        hold = 1'b0;
        cyc(lh + 23'h1, `LCC_CYC_DATA_RD); exp("neighbour", 0, 1, 0, 1);
        cyc(lh, `LCC_CYC_DATA_RD); exp("cleared", 1, 0, 1, 0);
        $display("test hold done");
    endtask
    task automatic t_lru;
        cyc(lx, `LCC_CYC_DATA_RD);
        cyc(lx + tag1, `LCC_CYC_DATA_RD);
        cyc(lx, `LCC_CYC_DATA_RD); // Makes the second tag the older one.
        cyc(lx + 2 * tag1, `LCC_CYC_DATA_RD); exp("third tag", 1, 0, 1, 0);
        cyc(lx, `LCC_CYC_DATA_RD); exp("recent kept", 0, 1, 0, 1);
        cyc(lx + tag1, `LCC_CYC_DATA_RD); exp("old replaced", 1, 0, 1, 0);
        $display("test replacement done");
    endtask
    task automatic t_bytes;
        for (int p = 1; p < 3; p++) begin
            {bhe_n, ble_n} = 2'(p);
            cyc(la, `LCC_CYC_DATA_RD);
            check("byte enables", 32'(be_seen), p);
        end
        {bhe_n, ble_n} = 2'h0;
        $display("test byte enables done");
    endtask
    // Modes: processor access, master access refused, master access allowed.
    task automatic t_regs;
        int rd, wt;
        rsel = 1'b1;
        for (int k = 0; k < 6; k++) begin
            hold = (k % 3 != 0);
            mst_n = (k % 3 != 2);
            {rd, wt} = '0;
            if (k < 3) ird_n = 1'b0;
            else iwr_n = 1'b0;
            for (int j = 0; j < 12; j++) begin
                @(negedge sys_clk);
                rd += (rrd === 1'b1);
                wt += (rwr === 1'b1);
                if (j == 3) {ird_n, iwr_n} = 2'h3;
            end
            check("register read pulses", rd, (k < 3 && k != 1));
            check("register write pulses", wt, (k > 2 && k != 4));
        end
        {rsel, hold, mst_n} = 3'h1;
        $display("test registers done");
    endtask
    initial begin
        #100us;
        err_total++;
        $display("watchdog expired");
        test_done;
    end
    initial begin
        repeat (3) @(negedge sys_clk);
        rst = 1'b0;
        repeat (2) @(negedge sys_clk);
        t_read;
        t_write;
        t_other;
        t_hold;
        t_lru;
        t_bytes;
        t_regs;
        test_done;
    end
endmodule // lcc_cycle_response_tb
